// ==== src/rif_pkg.sv ====
// Constants and carrier types for the route indicator frame emitter
package rif_pkg;
  // Frame framing bytes
  localparam logic [7:0]  RIF_START       = 8'h7E;    // Start delimiter
  localparam logic [7:0]  RIF_TYPE_RR     = 8'hA1;    // Route record indicator
  localparam logic [7:0]  RIF_TYPE_MTO    = 8'hA3;    // Many-to-one request indicator
  localparam logic [7:0]  RIF_CHK_BASE    = 8'hFF;    // Checksum is this minus byte sum
  // Frame positions of the header bytes
  localparam logic [9:0]  RIF_POS_START   = 10'h000;
  localparam logic [9:0]  RIF_POS_LEN_HI  = 10'h001;
  localparam logic [9:0]  RIF_POS_LEN_LO  = 10'h002;
  localparam logic [9:0]  RIF_POS_BODY    = 10'h003;  // First byte counted by length
  // Body offsets, relative to the frame type byte
  localparam logic [9:0]  RIF_BODY_TYPE   = 10'h000;
  localparam logic [9:0]  RIF_BODY_A64    = 10'h001;
  localparam logic [9:0]  RIF_BODY_A16    = 10'h009;
  localparam logic [9:0]  RIF_BODY_OPT    = 10'h00B;
  localparam logic [9:0]  RIF_BODY_HOPS   = 10'h00C;
  localparam logic [9:0]  RIF_BODY_RELAY  = 10'h00D;
  // Length field values
  localparam logic [15:0] RIF_LEN_MTO     = 16'h000C;
  localparam logic [15:0] RIF_LEN_RR_BASE = 16'h000D;
  // Bit positions
  localparam int          RIF_OPT_ACK     = 0;        // Receive option: acknowledged
  localparam int          RIF_OPT_BCAST   = 1;        // Receive option: broadcast
  localparam int          RIF_DEVOPT_LOW  = 6;        // Device options: low-memory mode
  localparam int          RIF_JCW_AUTO    = 6;        // Joining control: auto reply
  // Register map
  localparam logic [7:0]  RIF_ADDR_DEVOPT = 8'h00;
  localparam logic [7:0]  RIF_ADDR_JCW    = 8'h04;
  localparam logic [7:0]  RIF_ADDR_STATUS = 8'h08;
  localparam logic [31:0] RIF_DEVOPT_RST  = 32'h0000_0000;
  localparam logic [31:0] RIF_JCW_RST     = 32'h0000_0000;

  // Which indicator an event asks for
  typedef enum logic {
    RIF_KIND_RR  = 1'b0,
    RIF_KIND_MTO = 1'b1
  } rif_kind_type;

  // Emitter sequencing
  typedef enum logic {
    RIF_ST_IDLE = 1'b0,
    RIF_ST_SEND = 1'b1
  } rif_state_type;

  // One routing event from the network side
  typedef struct packed {
    rif_kind_type kind;
    logic [63:0]  addr64;
    logic [15:0]  addr16;
    logic         acked;
    logic         bcast;
    logic [7:0]   hops;
  } rif_event_type;

  // Destination of an automatic unicast reply
  typedef struct packed {
    logic [63:0] addr64;
    logic [15:0] addr16;
  } rif_dest_type;
endpackage : rif_pkg

// ==== src/rif_checksum.sv ====
// Running byte sum and frame checksum of the route indicator frame emitter
module rif_checksum (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clr_i,   // Start of a new frame
  input  wire logic       add_i,   // Byte below belongs to the checksum span
  input  wire logic [7:0] byte_i,
  output logic      [7:0] chk_o    // Checksum over the bytes added so far
);
  logic [7:0] sum_q;  // Low 8 bits of the sum, carries dropped on purpose

  // Clear wins so a stale sum never leaks into the next frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_i)
      sum_q <= 8'h00;
    else if (add_i)
      sum_q <= sum_q + byte_i;
  end

  // Depends only on the register, so no loop through the byte selector
  assign chk_o = rif_pkg::RIF_CHK_BASE - sum_q;
endmodule : rif_checksum

// ==== src/rif_route_tracker.sv ====
// Table of remote devices whose route has already been reported
module rif_route_tracker #(
  parameter int ENTRIES = 8  // Remote devices remembered at once
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [63:0] look_addr_i,    // Address checked this cycle
  output logic             hit_o,          // Route for look_addr_i already reported
  input  wire logic        learn_i,        // Remember learn_addr_i
  input  wire logic [63:0] learn_addr_i,
  input  wire logic        forget_i,       // Route to forget_addr_i has failed
  input  wire logic [63:0] forget_addr_i
);
  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  logic [63:0]  addr_q [ENTRIES];  // Remembered addresses
  logic [ENTRIES-1:0] vld_q;       // Entry in use
  logic [IW-1:0] wr_q;             // Round-robin victim, oldest is overwritten

  // Hit search over all valid entries
  always_comb
  begin
    hit_o = 1'b0;
    for (int i = 0; i < ENTRIES; i++)
      if (vld_q[i] && addr_q[i] == look_addr_i)
        hit_o = 1'b1;
  end

  // Learning fills entries; a failed route frees its entry for a new report
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vld_q <= '0;
      wr_q  <= '0;
    end
    else
    begin
      for (int i = 0; i < ENTRIES; i++)
        if (forget_i && vld_q[i] && addr_q[i] == forget_addr_i)
          vld_q[i] <= 1'b0;
      if (learn_i)
      begin
        addr_q[wr_q] <= learn_addr_i;
        vld_q[wr_q]  <= 1'b1;  // Learning wins over a same-cycle forget
        wr_q <= (wr_q == IW'(ENTRIES - 1)) ? '0 : wr_q + 1'b1;
      end
    end
  end
endmodule : rif_route_tracker

// ==== src/rif_emitter.sv ====
// Route record and many-to-one request indicator frame emitter
module rif_emitter #(
  parameter int TRACK_ENTRIES = 8  // Remote devices remembered in high-memory mode
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [7:0]             reg_addr_i,        // Register byte address
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,       // Valid the cycle after a read
  input  wire logic                   evt_valid_i,       // Routing event offered
  input  wire rif_pkg::rif_event_type evt_i,
  output logic                        evt_ready_o,       // Event taken when both high
  input  wire logic                   relay_we_i,        // Relay list load, idle only
  input  wire logic [7:0]             relay_idx_i,
  input  wire logic [15:0]            relay_addr_i,
  input  wire logic                   route_fail_i,      // Established route has failed
  input  wire logic [63:0]            route_fail_addr_i,
  output logic      [7:0]             tx_data_o,         // Serial frame byte
  output logic                        tx_valid_o,
  input  wire logic                   tx_ready_i,
  output logic                        reply_valid_o,     // Automatic unicast request
  output rif_pkg::rif_dest_type       reply_dest_o
);
  rif_pkg::rif_state_type state_q;     // Idle or sending
  rif_pkg::rif_event_type frm_q;       // Event being framed
  logic [15:0]            len_q;       // Length field of the current frame
  logic [9:0]             cur_q;       // Frame position of the byte in tx_data_q
  logic [7:0]             tx_data_q;
  logic                   tx_valid_q;
  logic                   rdy_q;       // Registered event ready
  logic [31:0]            devopt_q;    // Device options word
  logic [31:0]            jcw_q;       // Joining control word
  logic [31:0]            rdata_q;
  logic [15:0]            cnt_q;       // Frames completed, wraps
  logic                   reply_valid_q;
  rif_pkg::rif_dest_type  reply_q;
  logic [15:0]            relay_mem [256];  // Relay list, entry 0 sent first

  logic        take;       // Event accepted this cycle
  logic        known;      // Route already reported
  logic        emit;       // Accepted event produces a frame
  logic        hs;         // Byte handed to the serial port
  logic [9:0]  last_pos;   // Position of the checksum byte
  logic        last;
  logic [9:0]  nxt;        // Position of the next byte
  logic [9:0]  roff;       // Byte offset inside the relay list
  logic [7:0]  nxt_byte;
  logic [7:0]  chk;
  logic        chk_add;
  logic [15:0] len_d;

  // Length, body or checksum byte at a frame position; header start byte is loaded directly
  function automatic logic [7:0] frame_byte(input rif_pkg::rif_event_type f,
                                            input logic [15:0] len,
                                            input logic [9:0]  pos,
                                            input logic [15:0] rw,
                                            input logic [7:0]  ck);
    logic [9:0] b;
    logic [3:0] sh;
    b  = pos - rif_pkg::RIF_POS_BODY;
    sh = rif_pkg::RIF_BODY_A16[3:0] - 4'h1 - b[3:0];
    if (pos == rif_pkg::RIF_POS_LEN_HI)
      frame_byte = len[15:8];
    else if (pos == rif_pkg::RIF_POS_LEN_LO)
      frame_byte = len[7:0];
    else if (pos == len[9:0] + rif_pkg::RIF_POS_BODY)
      frame_byte = ck;
    else if (b == rif_pkg::RIF_BODY_TYPE)
      frame_byte = (f.kind == rif_pkg::RIF_KIND_RR) ? rif_pkg::RIF_TYPE_RR
                                                    : rif_pkg::RIF_TYPE_MTO;
    else if (b < rif_pkg::RIF_BODY_A16)
      frame_byte = 8'(f.addr64 >> {sh, 3'h0});
    else if (b == rif_pkg::RIF_BODY_A16)
      frame_byte = f.addr16[15:8];
    else if (b == rif_pkg::RIF_BODY_A16 + 10'h001)
      frame_byte = f.addr16[7:0];
    else if (b == rif_pkg::RIF_BODY_OPT)
      // Reserved byte of the many-to-one indicator stays zero
      frame_byte = (f.kind == rif_pkg::RIF_KIND_RR) ? {6'h00, f.bcast, f.acked}
                                                    : 8'h00;
    else if (b == rif_pkg::RIF_BODY_HOPS)
      frame_byte = f.hops;
    else
      frame_byte = (b[0] == rif_pkg::RIF_BODY_RELAY[0]) ? rw[15:8] : rw[7:0];
  endfunction : frame_byte

  // Event acceptance and memory-mode filter
  assign take  = evt_valid_i && rdy_q;
  assign emit  = (evt_i.kind == rif_pkg::RIF_KIND_MTO)
               || devopt_q[rif_pkg::RIF_DEVOPT_LOW]
               || (!known && !evt_i.bcast);
  assign len_d = (evt_i.kind == rif_pkg::RIF_KIND_MTO) ? rif_pkg::RIF_LEN_MTO
               : rif_pkg::RIF_LEN_RR_BASE + {7'h00, evt_i.hops, 1'b0};

  // Byte sequencing
  assign hs       = tx_valid_q && tx_ready_i;
  assign last_pos = len_q[9:0] + rif_pkg::RIF_POS_BODY;
  assign last     = cur_q == last_pos;
  assign nxt      = cur_q + 10'h001;
  assign roff     = nxt - rif_pkg::RIF_POS_BODY - rif_pkg::RIF_BODY_RELAY;
  assign nxt_byte = frame_byte(frm_q, len_q, nxt, relay_mem[roff[8:1]], chk);
  assign chk_add  = hs && !last && nxt >= rif_pkg::RIF_POS_BODY && nxt < last_pos;

  // Sum over the bytes between length and checksum
  rif_checksum u_chk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (take),
    .add_i  (chk_add),
    .byte_i (nxt_byte),
    .chk_o  (chk)
  );

  // Remote devices already reported in high-memory mode
  rif_route_tracker #(
    .ENTRIES (TRACK_ENTRIES)
  ) u_track (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .look_addr_i   (evt_i.addr64),
    .hit_o         (known),
    .learn_i       (take && emit && evt_i.kind == rif_pkg::RIF_KIND_RR),
    .learn_addr_i  (evt_i.addr64),
    .forget_i      (route_fail_i),
    .forget_addr_i (route_fail_addr_i)
  );

  // Frame sequencer; a new event is only taken once the checksum has gone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q    <= rif_pkg::RIF_ST_IDLE;
      rdy_q      <= 1'b1;
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      cur_q      <= rif_pkg::RIF_POS_START;
      len_q      <= 16'h0000;
      frm_q      <= '0;
    end
    else
    begin
      unique case (state_q)
        rif_pkg::RIF_ST_IDLE:
        begin
          if (take && emit)
          begin
            frm_q      <= evt_i;
            len_q      <= len_d;
            tx_data_q  <= rif_pkg::RIF_START;
            tx_valid_q <= 1'b1;
            cur_q      <= rif_pkg::RIF_POS_START;
            rdy_q      <= 1'b0;
            state_q    <= rif_pkg::RIF_ST_SEND;
          end
        end
        rif_pkg::RIF_ST_SEND:
        begin
          if (hs && last)
          begin
            tx_valid_q <= 1'b0;
            rdy_q      <= 1'b1;
            state_q    <= rif_pkg::RIF_ST_IDLE;
          end
          else if (hs)
          begin
            tx_data_q <= nxt_byte;
            cur_q     <= nxt;
          end
        end
      endcase
    end
  end

  // Relay list; writes during a frame are dropped so the list cannot tear
  always_ff @(posedge clk_i)
  begin
    if (relay_we_i && rdy_q)
      relay_mem[relay_idx_i] <= relay_addr_i;
  end

  // Automatic unicast answer; its reply payload never reaches the serial port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reply_valid_q <= 1'b0;
      reply_q       <= '0;
    end
    else
    begin
      reply_valid_q <= take && evt_i.kind == rif_pkg::RIF_KIND_MTO
                    && jcw_q[rif_pkg::RIF_JCW_AUTO];
      if (take && evt_i.kind == rif_pkg::RIF_KIND_MTO)
        reply_q <= '{addr64: evt_i.addr64, addr16: evt_i.addr16};
    end
  end

  // Completed frame counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 16'h0000;
    else if (hs && last)
      cnt_q <= cnt_q + 16'h0001;
  end

  // Register writes; unmapped addresses are ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      devopt_q <= rif_pkg::RIF_DEVOPT_RST;
      jcw_q    <= rif_pkg::RIF_JCW_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == rif_pkg::RIF_ADDR_DEVOPT)
        devopt_q <= reg_wdata_i;
      if (reg_addr_i == rif_pkg::RIF_ADDR_JCW)
        jcw_q <= reg_wdata_i;
    end
  end

  // Register reads; data stands for one cycle only, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !reg_rd_i)
      rdata_q <= 32'h0000_0000;
    else if (reg_addr_i == rif_pkg::RIF_ADDR_DEVOPT)
      rdata_q <= devopt_q;
    else if (reg_addr_i == rif_pkg::RIF_ADDR_JCW)
      rdata_q <= jcw_q;
    else if (reg_addr_i == rif_pkg::RIF_ADDR_STATUS)
      rdata_q <= {cnt_q, 15'h0000, state_q == rif_pkg::RIF_ST_SEND};
    else
      rdata_q <= 32'h0000_0000;
  end

  assign reg_rdata_o   = rdata_q;
  assign evt_ready_o   = rdy_q;
  assign tx_data_o     = tx_data_q;
  assign tx_valid_o    = tx_valid_q;
  assign reply_valid_o = reply_valid_q;
  assign reply_dest_o  = reply_q;

  // Independent byte sum over the handed-over body, for the checksum check
  logic [7:0] sum_h_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || take)
      sum_h_q <= 8'h00;
    else if (hs && cur_q >= rif_pkg::RIF_POS_BODY && !last)
      sum_h_q <= sum_h_q + tx_data_q;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take_rr;
    take && evt_i.kind == rif_pkg::RIF_KIND_RR;
  endsequence
  sequence s_take_mto;
    take && evt_i.kind == rif_pkg::RIF_KIND_MTO;
  endsequence

  property p_start;
    take && emit |=> tx_valid_o && tx_data_o == rif_pkg::RIF_START && !evt_ready_o;
  endproperty
  a_start: assert property (p_start) else $error("frame did not open with start");

  property p_chk;
    hs && last |-> 8'(tx_data_o + sum_h_q) == rif_pkg::RIF_CHK_BASE;
  endproperty
  a_chk: assert property (p_chk) else $error("checksum byte wrong");

  property p_type;
    tx_valid_o && cur_q == rif_pkg::RIF_POS_BODY |->
      tx_data_o == (frm_q.kind == rif_pkg::RIF_KIND_RR ? rif_pkg::RIF_TYPE_RR
                                                       : rif_pkg::RIF_TYPE_MTO);
  endproperty
  a_type: assert property (p_type) else $error("frame type byte wrong");

  property p_src;
    tx_valid_o && cur_q == rif_pkg::RIF_POS_BODY + rif_pkg::RIF_BODY_A64 |->
      tx_data_o == frm_q.addr64[63:56];
  endproperty
  a_src: assert property (p_src) else $error("source not at offset 4");

  property p_opt;
    tx_valid_o && cur_q == rif_pkg::RIF_POS_BODY + rif_pkg::RIF_BODY_OPT |->
      tx_data_o == (frm_q.kind == rif_pkg::RIF_KIND_RR ? {6'h00, frm_q.bcast, frm_q.acked}
                                                       : 8'h00);
  endproperty
  a_opt: assert property (p_opt) else $error("options byte wrong");

  property p_hops;
    tx_valid_o && frm_q.kind == rif_pkg::RIF_KIND_RR
      && cur_q == rif_pkg::RIF_POS_BODY + rif_pkg::RIF_BODY_HOPS |-> tx_data_o == frm_q.hops;
  endproperty
  a_hops: assert property (p_hops) else $error("hop count byte wrong");

  property p_drop;
    s_take_rr ##0 (!devopt_q[rif_pkg::RIF_DEVOPT_LOW] && known) |=> !tx_valid_o[*2];
  endproperty
  a_drop: assert property (p_drop) else $error("repeat route reported");

  property p_low;
    s_take_rr ##0 devopt_q[rif_pkg::RIF_DEVOPT_LOW] |=> tx_valid_o;
  endproperty
  a_low: assert property (p_low) else $error("low-memory event not reported");

  property p_auto;
    s_take_mto |=> reply_valid_o == jcw_q[rif_pkg::RIF_JCW_AUTO]
                && reply_dest_o.addr64 == $past(evt_i.addr64) ##1 !reply_valid_o;
  endproperty
  a_auto: assert property (p_auto) else $error("automatic reply wrong");

  property p_hold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
endmodule : rif_emitter

// ==== tb/rif_host_sink.sv ====
// Host-side sink model that takes frame bytes from the emitter
module rif_host_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] tx_data_i,   // Byte offered by the emitter
  input  wire logic       tx_valid_i,
  input  wire logic       slow_i,      // Stall every other cycle when high
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rx_q[$];          // Received bytes kept for later use
  int         answers_owed = 0;  // Many-to-one indicators received so far; each asks for a unicast answer

  // Ready is prompt by default; the slow mode stalls mid-frame to stress holding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_ready_o <= 1'b1;
    else
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  end

  // A byte is taken only on a handshake edge
  always @(posedge clk_i)
  begin
    if (!rst_i && tx_valid_i && tx_ready_o)
    begin
      rx_q.push_back(tx_data_i);
      // A many-to-one type byte means the concentrator waits for a unicast
      if (rx_q.size() == 4 && tx_data_i == rif_pkg::RIF_TYPE_MTO)
        answers_owed++;
    end
  end
endmodule : rif_host_sink

// ==== tb/route_indicator_frame_emitter_bench.sv ====
// Self-checking bench for the route indicator frame emitter
module route_indicator_frame_emitter_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clk_i, rst_i, reg_wr_i, reg_rd_i, evt_valid_i, relay_we_i;
  logic [7:0]            reg_addr_i, relay_idx_i, tx_data_o;
  logic [31:0]           reg_wdata_i, reg_rdata_o, rd;
  rif_pkg::rif_event_type evt_i;
  logic                  evt_ready_o, route_fail_i, tx_valid_o, tx_ready_i, reply_valid_o;
  logic [15:0]           relay_addr_i;
  logic [63:0]           route_fail_addr_i;
  rif_pkg::rif_dest_type reply_dest_o, reply_last;
  logic                  slow;          // Sink stall mode
  logic [7:0]            exp_q[$];      // Expected frame bytes
  int                    miscompares, comparisons, cycles, replies;

  rif_emitter #(.TRACK_ENTRIES(8)) dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .reg_addr_i        (reg_addr_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_wr_i          (reg_wr_i),
    .reg_rd_i          (reg_rd_i),
    .reg_rdata_o       (reg_rdata_o),
    .evt_valid_i       (evt_valid_i),
    .evt_i             (evt_i),
    .evt_ready_o       (evt_ready_o),
    .relay_we_i        (relay_we_i),
    .relay_idx_i       (relay_idx_i),
    .relay_addr_i      (relay_addr_i),
    .route_fail_i      (route_fail_i),
    .route_fail_addr_i (route_fail_addr_i),
    .tx_data_o         (tx_data_o),
    .tx_valid_o        (tx_valid_o),
    .tx_ready_i        (tx_ready_i),
    .reply_valid_o     (reply_valid_o),
    .reply_dest_o      (reply_dest_o)
  );
  rif_host_sink host (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .slow_i(slow), .tx_ready_o(tx_ready_i));

  // Free-running 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Count automatic reply pulses and keep the last destination
  always @(posedge clk_i)
  begin
    if (!rst_i && reply_valid_o)
    begin
      replies++;
      reply_last = reply_dest_o;
    end
  end

  // Hang guard: the tests need a few thousand cycles at most
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Register bus: one-cycle strobes, read data in the following cycle only
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    rd = reg_rdata_o;
  endtask : reg_read

  // Offer one event and hold it until the edge that takes it
  task automatic send(input logic k, input logic [63:0] a64, input logic [15:0] a16,
                      input logic ack, input logic bc, input logic [7:0] hops);
    @(posedge clk_i);
    evt_valid_i <= 1'b1;
    evt_i <= '{kind: rif_pkg::rif_kind_type'(k), addr64: a64, addr16: a16,
               acked: ack, bcast: bc, hops: hops};
    while (!evt_ready_o)
      @(negedge clk_i);
    @(posedge clk_i);
    evt_valid_i <= 1'b0;
  endtask : send

  // Expected frame: delimiter, length, body, then FF minus body sum
  task automatic expect_frame(input logic k, input logic [63:0] a64, input logic [15:0] a16,
                              input logic [7:0] opt, input logic [7:0] hops);
    logic [7:0] body[$];
    logic [7:0] sum;
    body.push_back(k ? rif_pkg::RIF_TYPE_MTO : rif_pkg::RIF_TYPE_RR);
    for (int i = 7; i >= 0; i--)
      body.push_back(a64[8*i +: 8]);
    body.push_back(a16[15:8]);
    body.push_back(a16[7:0]);
    body.push_back(k ? 8'h00 : opt);
    if (!k)
      body.push_back(hops);
    for (int i = 0; i < int'(hops) && !k; i++)
    begin
      body.push_back(8'hCC - 8'(8'h11 * i));  // Relays CCCC, BBBB, AAAA
      body.push_back(8'hCC - 8'(8'h11 * i));
    end
    sum = 8'h00;
    foreach (body[i])
      sum += body[i];
    exp_q = {8'h7E, 8'h00, 8'(body.size()), body, 8'(8'hFF - sum)};
  endtask : expect_frame

  // Wait for the whole frame and compare it byte by byte
  task automatic check_frame(input string name);
    logic [7:0] seen;
    for (int n = 0; n < 400 && host.rx_q.size() < exp_q.size(); n++)
      @(negedge clk_i);
    check({name, " size"}, host.rx_q.size(), exp_q.size());
    foreach (exp_q[i])
    begin
      // A missing byte shows as unknown and never matches
      seen = (i < host.rx_q.size()) ? host.rx_q[i] : 8'hXX;
      if (i < 3 || i == exp_q.size() - 1)
        check(name, 32'(seen), 32'(exp_q[i]));
      else if (exp_q[3] == rif_pkg::RIF_TYPE_RR)
        check(name, 32'(seen), 32'(exp_q[i]));
      else
        check(name, 32'(seen), 32'(exp_q[i]));
    end
    host.rx_q.delete();
    $display("Test done: %s", name);
  endtask : check_frame

  // A dropped event leaves the serial output silent
  task automatic check_none(input string name);
    repeat (40) @(negedge clk_i);
    check(name, host.rx_q.size(), 0);
    check({name, " ready"}, 32'(evt_ready_o), 32'h0000_0001);
    $display("Test done: %s", name);
  endtask : check_none

  initial
  begin
    {reg_wr_i, reg_rd_i, evt_valid_i, relay_we_i, route_fail_i, slow} = '0;
    {reg_addr_i, relay_idx_i, reg_wdata_i, relay_addr_i, route_fail_addr_i} = '0;
    evt_i = '0;
    {miscompares, comparisons, cycles, replies} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped and read-only places
    for (int i = 0; i < 16; i += 4)
    begin
      reg_read(8'(i));
      check("reset reg", rd, 32'h0000_0000);
    end
    reg_write(8'h08, 32'hFFFF_FFFF);
    reg_read(8'h08);
    check("status ro", rd, 32'h0000_0000);
    reg_write(8'h00, 32'h0000_0040);
    reg_read(8'h00);
    check("devopt", rd, 32'h0000_0040);
    $display("Test done: registers");
    // Relay list, destination end first
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      relay_we_i   <= 1'b1;
      relay_idx_i  <= 8'(i);
      relay_addr_i <= {2{8'hCC - 8'(8'h11 * i)}};
    end
    @(posedge clk_i);
    relay_we_i <= 1'b0;
    // Low-memory mode reports every transmission, even a repeat
    send(1'b0, 64'h1122_3344_5566_7788, 16'hDDDD, 1'b1, 1'b0, 8'h03);
    expect_frame(1'b0, 64'h1122_3344_5566_7788, 16'hDDDD, 8'h01, 8'h03);
    check_frame("low mem first");
    slow = 1'b1;
    send(1'b0, 64'h1122_3344_5566_7788, 16'hDDDD, 1'b0, 1'b1, 8'h03);
    expect_frame(1'b0, 64'h1122_3344_5566_7788, 16'hDDDD, 8'h02, 8'h03);
    check_frame("low mem repeat");
    slow = 1'b0;
    // High-memory mode: first unicast only, again after a route failure
    reg_write(8'h00, 32'h0000_0000);
    send(1'b0, 64'hA5A5_0000_1234_0001, 16'h0102, 1'b1, 1'b0, 8'h00);
    expect_frame(1'b0, 64'hA5A5_0000_1234_0001, 16'h0102, 8'h01, 8'h00);
    check_frame("high mem first");
    send(1'b0, 64'hA5A5_0000_1234_0001, 16'h0102, 1'b1, 1'b0, 8'h00);
    check_none("high mem repeat");
    send(1'b0, 64'hA5A5_0000_1234_0002, 16'h0103, 1'b0, 1'b1, 8'h00);
    check_none("high mem broadcast");
    @(posedge clk_i);
    route_fail_i      <= 1'b1;
    route_fail_addr_i <= 64'hA5A5_0000_1234_0001;
    @(posedge clk_i);
    route_fail_i <= 1'b0;
    send(1'b0, 64'hA5A5_0000_1234_0001, 16'h0102, 1'b1, 1'b0, 8'h00);
    expect_frame(1'b0, 64'hA5A5_0000_1234_0001, 16'h0102, 8'h01, 8'h00);
    check_frame("high mem after failure");
    // Many-to-one indicator, without and then with the automatic reply
    send(1'b1, 64'h0F0E_0D0C_8765_4321, 16'h0000, 1'b1, 1'b1, 8'h05);
    expect_frame(1'b1, 64'h0F0E_0D0C_8765_4321, 16'h0000, 8'h00, 8'h00);
    check_frame("mto plain");
    check("no reply", replies, 0);
    reg_write(8'h04, 32'h0000_0040);
    send(1'b1, 64'h0F0E_0D0C_8765_4322, 16'h4455, 1'b0, 1'b0, 8'h00);
    expect_frame(1'b1, 64'h0F0E_0D0C_8765_4322, 16'h4455, 8'h00, 8'h00);
    check_frame("mto auto reply");
    check("reply count", replies, 1);
    check("reply dest hi", reply_last.addr64[63:32], 32'h0F0E_0D0C);
    check("reply dest lo", reply_last.addr64[31:0], 32'h8765_4322);
    check("reply dest short", {16'h0000, reply_last.addr16}, 32'h0000_4455);
    check("answers owed", host.answers_owed, 2);
    reg_read(8'h08);
    check("frame count", rd, 32'h0006_0000);
    report_and_stop();
  end
endmodule : route_indicator_frame_emitter_bench
